// [rtl/loop_status_pkg.sv]
// package for the loop two status word: offset, bit positions, reset values, types
// assumes one 200 MHz clock shared by the status logic and the host refresh logic
package loop_status_pkg;

    localparam logic [3:0]  LOOP_TWO_STATUS_OFS = 4'h9;
    localparam int          WORD_W              = 16;

    localparam int          BIT_SAVE_DONE       = 15;
    localparam int          BIT_SENSOR_FAULT    = 14;
    localparam int          BIT_FATAL_ERR       = 12;
    localparam int          BIT_STANDBY         = 11;
    localparam int          BIT_PID_CALC        = 10;
    localparam int          BIT_SETTING_ERR     = 9;
    localparam int          BIT_STOPPED         = 8;
    localparam int          BIT_CTRL_OUT        = 4;
    localparam int          BIT_AUTOTUNE        = 3;
    localparam int          BIT_ALARM1          = 1;
    localparam int          BIT_ALARM2          = 0;
    localparam int          SAVE_REQ_BIT        = 14;

    localparam logic [15:0] STATUS_RESET        = 16'h0800;
    localparam logic [15:0] UNUSED_MASK         = 16'h20E4;
    localparam logic        STANDBY_RESET       = 1'b1;
    localparam logic        PID_CALC_RESET      = 1'b0;
    localparam logic        SAVE_REQ_RESET      = 1'b0;

    typedef struct packed {
        logic save_done;
        logic sensor_fault;
        logic unused_13;
        logic fatal_err;
        logic standby;
        logic pid_calc;
        logic setting_err;
        logic stopped;
        logic [2:0] unused_7_5;
        logic ctrl_out;
        logic autotune_active_bit;
        logic unused_2;
        logic first_alarm_bit;
        logic second_alarm_bit;
    } status_t;

    typedef enum logic [1:0] {
        SV_IDLE = 2'b00,
        SV_BUSY = 2'b01,
        SV_DONE = 2'b11
    } save_state_t;

endpackage

// [rtl/loop_status_word.sv]
// loop two status word: sticky save/standby/pid flags and a per-refresh snapshot
// assumes every input comes from logic on MCLK_IN; the host word is held in I/O memory
`timescale 1ns/1ps

module loop_status_word
    import loop_status_pkg::*;
(
    input  wire logic        MCLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        REFRESH_IN,
    input  wire logic [15:0] HOST_SAVE_WORD_IN,
    input  wire logic        SAVE_FINISHED_IN,
    input  wire logic        SENSOR_ABSENT_IN,
    input  wire logic        SENSOR_BROKEN_IN,
    input  wire logic        RANGE_EXCEEDED_IN,
    input  wire logic        CJC_FAIL_IN,
    input  wire logic        HOST_WDT_FAIL_IN,
    input  wire logic        RESTART_IN,
    input  wire logic        PID_UPDATED_IN,
    input  wire logic        PID_SENT_IN,
    input  wire logic        SETTING_INVALID_IN,
    input  wire logic        CONTROL_RUN_IN,
    input  wire logic        CTRL_OUT_ON_IN,
    input  wire logic        AUTOTUNE_RUN_IN,
    input  wire logic        ALARM1_INSIDE_IN,
    input  wire logic        ALARM2_INSIDE_IN,
    output logic [15:0]      STATUS_WORD_OUT,
    output logic             SAVE_START_OUT
);

    save_state_t save_state_ff;
    save_state_t nxt_save_state;
    logic        save_req_ff;
    logic        nxt_save_req;
    logic        save_edge;
    logic        standby_ff;
    logic        nxt_standby;
    logic        pid_calc_ff;
    logic        nxt_pid_calc;
    status_t     live_status;
    logic [15:0] status_ff;
    logic [15:0] nxt_status;

    function automatic logic save_is_done(input save_state_t st);
        save_is_done = (st == SV_DONE);
    endfunction

    // host save request edge, sampled every cycle
    always_comb
    begin
        nxt_save_req = HOST_SAVE_WORD_IN[SAVE_REQ_BIT];
        save_edge    = HOST_SAVE_WORD_IN[SAVE_REQ_BIT] & ~save_req_ff;
    end

    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            save_req_ff <= SAVE_REQ_RESET;
        else
            save_req_ff <= nxt_save_req;
    end

    // a new request during a write restarts it; the writer sees a fresh start pulse
    always_comb
    begin
        nxt_save_state = save_state_ff;
        case (save_state_ff)
            SV_IDLE:
            begin
                if (save_edge)
                    nxt_save_state = SV_BUSY;
            end
            SV_BUSY:
            begin
                if (save_edge)
                    nxt_save_state = SV_BUSY;
                else if (SAVE_FINISHED_IN)
                    nxt_save_state = SV_DONE;
            end
            SV_DONE:
            begin
                if (save_edge)
                    nxt_save_state = SV_BUSY;
            end
            default:
                nxt_save_state = SV_IDLE;
        endcase
    end

    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            save_state_ff <= SV_IDLE;
        else
            save_state_ff <= nxt_save_state;
    end

    assign SAVE_START_OUT = save_edge;

    // standby: a restart in the refresh cycle wins over the clear
    always_comb
    begin
        nxt_standby = standby_ff;
        if (RESTART_IN)
            nxt_standby = 1'b1;
        else if (REFRESH_IN)
            nxt_standby = 1'b0;
    end

    // pid flag: an update arriving with the send acknowledge stays visible
    always_comb
    begin
        nxt_pid_calc = pid_calc_ff;
        if (PID_UPDATED_IN)
            nxt_pid_calc = 1'b1;
        else if (PID_SENT_IN)
            nxt_pid_calc = 1'b0;
    end

    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            standby_ff  <= STANDBY_RESET;
            pid_calc_ff <= PID_CALC_RESET;
        end
        else
        begin
            standby_ff  <= nxt_standby;
            pid_calc_ff <= nxt_pid_calc;
        end
    end

    always_comb
    begin
        live_status                     = '0;
        live_status.save_done           = save_is_done(save_state_ff);
        live_status.sensor_fault        = SENSOR_ABSENT_IN | SENSOR_BROKEN_IN
                                        | RANGE_EXCEEDED_IN;
        live_status.fatal_err           = CJC_FAIL_IN | HOST_WDT_FAIL_IN;
        live_status.standby             = standby_ff;
        live_status.pid_calc            = pid_calc_ff;
        live_status.setting_err         = SETTING_INVALID_IN;
        live_status.stopped             = ~CONTROL_RUN_IN;
        live_status.ctrl_out            = CTRL_OUT_ON_IN;
        live_status.autotune_active_bit = AUTOTUNE_RUN_IN;
        live_status.first_alarm_bit     = ALARM1_INSIDE_IN;
        live_status.second_alarm_bit    = ALARM2_INSIDE_IN;
    end

    // held between refreshes so the host never sees a half-updated word
    always_comb
    begin
        nxt_status = status_ff;
        if (REFRESH_IN)
            nxt_status = live_status & ~UNUSED_MASK;
    end

    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
            status_ff <= STATUS_RESET;
        else
            status_ff <= nxt_status;
    end

    assign STATUS_WORD_OUT = status_ff;

    sequence s_refresh;
        REFRESH_IN;
    endsequence

    sequence s_save_req;
        HOST_SAVE_WORD_IN[SAVE_REQ_BIT] && !save_req_ff;
    endsequence

    sequence s_write_done;
        save_state_ff == SV_BUSY && SAVE_FINISHED_IN && !save_edge;
    endsequence

    a_save_done_set: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        s_write_done ##1 s_refresh |=> STATUS_WORD_OUT[BIT_SAVE_DONE])
        else $error("save done not shown after write finished");

    a_save_start: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        s_save_req |-> SAVE_START_OUT ##1 save_state_ff == SV_BUSY)
        else $error("save request did not start a write");

    a_save_clear: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        s_save_req ##1 (!SAVE_FINISHED_IN && REFRESH_IN) |=> !STATUS_WORD_OUT[BIT_SAVE_DONE])
        else $error("save done not cleared by save request");

    a_save_reset: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        $rose(RSTN_IN) |-> !STATUS_WORD_OUT[BIT_SAVE_DONE])
        else $error("save done set after reset");

    a_sensor_fault: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        s_refresh |=> STATUS_WORD_OUT[BIT_SENSOR_FAULT] ==
            ($past(SENSOR_ABSENT_IN) | $past(SENSOR_BROKEN_IN) | $past(RANGE_EXCEEDED_IN)))
        else $error("sensor fault bit wrong");

    a_fatal_error: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        s_refresh |=> STATUS_WORD_OUT[BIT_FATAL_ERR] == ($past(CJC_FAIL_IN) | $past(HOST_WDT_FAIL_IN)))
        else $error("fatal error bit wrong");

    a_standby_ends: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (REFRESH_IN && !RESTART_IN) ##1 (REFRESH_IN && !RESTART_IN)
            |=> !STATUS_WORD_OUT[BIT_STANDBY])
        else $error("standby still shown after refresh");

    a_standby_restart: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        RESTART_IN ##1 REFRESH_IN |=> STATUS_WORD_OUT[BIT_STANDBY])
        else $error("standby not shown after restart");

    a_pid_set: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        PID_UPDATED_IN ##1 REFRESH_IN |=> STATUS_WORD_OUT[BIT_PID_CALC])
        else $error("pid flag not set after update");

    a_pid_sent: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (PID_SENT_IN && !PID_UPDATED_IN) ##1 (REFRESH_IN && !PID_UPDATED_IN)
            |=> !STATUS_WORD_OUT[BIT_PID_CALC])
        else $error("pid flag not cleared after send");

    a_setting_err: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        s_refresh |=> STATUS_WORD_OUT[BIT_SETTING_ERR] == $past(SETTING_INVALID_IN))
        else $error("setting error bit wrong");

    a_stopped_bit: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        s_refresh |=> STATUS_WORD_OUT[BIT_STOPPED] != $past(CONTROL_RUN_IN))
        else $error("stopped bit wrong");

    a_ctrl_out: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        s_refresh |=> STATUS_WORD_OUT[BIT_CTRL_OUT] == $past(CTRL_OUT_ON_IN))
        else $error("control output bit wrong");

    a_autotune_bit: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        s_refresh |=> STATUS_WORD_OUT[BIT_AUTOTUNE] == $past(AUTOTUNE_RUN_IN))
        else $error("autotune bit wrong");

    a_alarm_bits: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        s_refresh |=> STATUS_WORD_OUT[BIT_ALARM1] == $past(ALARM1_INSIDE_IN)
            && STATUS_WORD_OUT[BIT_ALARM2] == $past(ALARM2_INSIDE_IN))
        else $error("alarm bits wrong");

    a_unused_zero: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (STATUS_WORD_OUT & UNUSED_MASK) == '0)
        else $error("unused status bit set");

    a_word_holds: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        !REFRESH_IN |=> $stable(STATUS_WORD_OUT))
        else $error("status word changed between refreshes");

    a_pid_update_wins: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (PID_UPDATED_IN && PID_SENT_IN) ##1 s_refresh |=> STATUS_WORD_OUT[BIT_PID_CALC])
        else $error("pid flag lost when update met send");

    a_finish_ignored: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (save_state_ff == SV_IDLE && SAVE_FINISHED_IN) ##1 s_refresh |=> !STATUS_WORD_OUT[BIT_SAVE_DONE])
        else $error("save done set without a save request");

    a_request_clears: assert property (
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        s_save_req |=> save_state_ff != SV_DONE)
        else $error("save done kept after save request");

endmodule // loop_status_word

// [test/host_io_model.sv]
// host side model: refresh strobes, the save request word and the pid sent pulse
// assumes the bench calls its tasks; everything it drives moves on the falling edge
`timescale 1ns/1ps

module host_io_model (
    input  wire logic        clk_in,
    output logic             refresh_out,
    output logic [15:0]      save_word_out,
    output logic             pid_sent_out
);
    logic        save_ff;
    logic [15:0] noise_ff = 16'hA5C3;

    initial
    begin
        refresh_out  = 1'b0;
        pid_sent_out = 1'b0;
        save_ff      = 1'b0;
    end

    // other loops' request bits churn, so only bit 14 may matter
    always @(negedge clk_in) noise_ff <= noise_ff + 16'h0001;
    assign save_word_out = {noise_ff[15], save_ff, noise_ff[13:0]};

    task automatic refresh();
        @(negedge clk_in);
        refresh_out = 1'b1;
        @(negedge clk_in);
        refresh_out = 1'b0;
    endtask

    // refresh held for n edges back to back
    task automatic refresh_burst(input int n);
        @(negedge clk_in);
        refresh_out = 1'b1;
        repeat (n) @(negedge clk_in);
        refresh_out = 1'b0;
    endtask

    task automatic set_save(input logic lvl);
        @(negedge clk_in);
        save_ff = lvl;
    endtask

    task automatic send_pid();
        @(negedge clk_in);
        pid_sent_out = 1'b1;
        @(negedge clk_in);
        pid_sent_out = 1'b0;
    endtask
endmodule // host_io_model

// [test/loop_status_word_bench.sv]
// self-checking bench for the loop two status word
// assumes host_io_model makes refreshes; bench inputs change on falling edges
`timescale 1ns/1ps

module loop_status_word_bench;
    import loop_status_pkg::*;
    logic        mclk;
    logic        rstn;
    logic        refresh;
    logic [15:0] save_word;
    logic        pid_sent;
    logic [2:0]  pulse_v;
    logic [10:0] lvl_v;
    logic [15:0] status_word;
    logic        save_start;
    status_t     exp_s;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          pos [11] = '{14, 14, 14, 12, 12, 9, 8, 4, 3, 1, 0};

    host_io_model host_io_model_i (.clk_in(mclk), .refresh_out(refresh), .save_word_out(save_word),
        .pid_sent_out(pid_sent));

    loop_status_word loop_status_word_i (
        .MCLK_IN(mclk), .RSTN_IN(rstn), .REFRESH_IN(refresh), .HOST_SAVE_WORD_IN(save_word),
        .SAVE_FINISHED_IN(pulse_v[0]), .PID_UPDATED_IN(pulse_v[1]), .RESTART_IN(pulse_v[2]),
        .SENSOR_ABSENT_IN(lvl_v[0]), .SENSOR_BROKEN_IN(lvl_v[1]), .RANGE_EXCEEDED_IN(lvl_v[2]),
        .CJC_FAIL_IN(lvl_v[3]), .HOST_WDT_FAIL_IN(lvl_v[4]), .SETTING_INVALID_IN(lvl_v[5]),
        .CONTROL_RUN_IN(lvl_v[6]), .CTRL_OUT_ON_IN(lvl_v[7]), .AUTOTUNE_RUN_IN(lvl_v[8]),
        .ALARM1_INSIDE_IN(lvl_v[9]), .ALARM2_INSIDE_IN(lvl_v[10]), .PID_SENT_IN(pid_sent),
        .STATUS_WORD_OUT(status_word), .SAVE_START_OUT(save_start));

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic check_v(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    // one refresh, then the word is settled at the following falling edge
    task automatic read_exp(input logic [15:0] exp);
        host_io_model_i.refresh();
        check_v(status_word, exp);
    endtask

    task automatic pulse(input logic [2:0] m);
        @(negedge mclk);
        pulse_v = m;
        @(negedge mclk);
        pulse_v = 3'h0;
    endtask

    // event pulses in one cycle, refresh in the very next, so the flags are caught at once
    task automatic pulse_read(input logic [2:0] m, input logic sent, input logic [15:0] exp);
        fork
            pulse(m);
            if (sent)
                host_io_model_i.send_pid();
            begin
                @(negedge mclk);
                host_io_model_i.refresh();
            end
        join
        check_v(status_word, exp);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // whole run is under a hundred cycles; this is far beyond it
    initial
    begin
        #100000;
        error_cnt++;
        print_verdict();
    end

    initial
    begin
        rstn    = 1'b0;
        pulse_v = 3'h0;
        lvl_v   = 11'h040;
        repeat (8) @(negedge mclk);
        check_v(status_word, STATUS_RESET);
        rstn = 1'b1;
        read_exp(16'h0800);
        read_exp(16'h0000);
        for (int i = 0; i < 11; i++)
        begin
            lvl_v = 11'h040 ^ (11'h001 << i);
            read_exp(16'h0001 << pos[i]);
        end
        lvl_v = 11'h7BF;
        read_exp(16'h531B);
        lvl_v = 11'h040;
        repeat (3) @(negedge mclk);
        check_v(status_word, 16'h531B);
        read_exp(16'h0000);
        pulse_read(3'h1, 1'b0, 16'h0000);
        host_io_model_i.set_save(1'b1);
        #1;
        check_v({15'h0000, save_start}, 16'h0001);
        exp_s = '0;
        exp_s.save_done = 1'b1;
        pulse_read(3'h1, 1'b0, exp_s);
        host_io_model_i.set_save(1'b0);
        host_io_model_i.set_save(1'b1);
        read_exp(16'h0000);
        pulse_read(3'h2, 1'b0, 16'h0400);
        pulse_read(3'h0, 1'b1, 16'h0000);
        pulse_read(3'h2, 1'b1, 16'h0400);
        pulse_read(3'h4, 1'b0, 16'h0C00);
        read_exp(16'h0400);
        pulse(3'h4);
        host_io_model_i.refresh_burst(2);
        check_v(status_word, 16'h0400);
        print_verdict();
    end
endmodule // loop_status_word_bench
